// >>> hdl/tcc_top.v
// four-channel timer capture/compare block with apb register access
// assumes channel pins are synchronous to core_clk; pads resolve pin level from oe_n
//
// Summary of operation
// RULE1: input capture sets channel flag on the selected pin edge
// RULE2: output compare sets channel flag when counter equals compare value
// RULE3: flag clears by reading control with flag set, then writing zero
// RULE4: an event between that read and write keeps the flag set
// RULE5: writing one to the flag does nothing; reset clears it
// RULE6: interrupt request only while the channel enable bit is one
// RULE7: buffered-mode bit exists only on channels 0 and 2
// RULE8: buffered mode on even channel disables next odd channel and its pin
// RULE9: nonzero edge field: mode bit one means compare, zero means capture
// RULE10: zero edge field frees the pin; mode bit picks preset level
// RULE11: capture edge field: 01 rising, 10 falling, 11 either
// RULE12: compare edge field: 01 toggle, 10 clear, 11 set
// RULE13: buffered bit forces buffered compare whatever the mode bit
// RULE14: software halts and clears counter before changing channel mode
// RULE15: pin must be stable two clocks before capture is enabled
// RULE16: toggle-on-overflow toggles pin at overflow in compare mode only
// RULE17: overflow action wins over a same-cycle compare when toggling
// RULE18: full-duty bit with toggle off forces 100% pwm output
// RULE19: full-duty changes take effect from the next pwm period
// RULE20: software clears the counter before writing new modulo
// RULE21: reset clears edge and mode bits, pins start disconnected
// RULE22: reading value high byte blocks capture until low byte read
// RULE23: overflow is signalled when counter wraps after modulo value
// RULE24: counter clear zeroes counter only and always reads zero
// RULE25: buffered compare alternates even and odd values at each overflow
`include "tcc_defines.vh"

module tcc_top
#(
	parameter ADDR_WIDTH = 12,
	parameter CNT_WIDTH = 16,
	parameter NUM_CH = 4
)
(
	input wire core_clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [NUM_CH-1:0] channel_pin_in,
	output wire [NUM_CH-1:0] channel_pin_out,
	output wire [NUM_CH-1:0] channel_pin_oe_n,
	output wire [NUM_CH-1:0] channel_irq
);
	reg [31:0] prdata_ff;
	reg pready_ff;
	reg pslverr_ff;
	reg halt_ff;
	reg clr_ff;
	reg wrap_flag_ff;
	reg wrap_arm_ff;
	reg [CNT_WIDTH-1:0] mod_ff;
	wire [CNT_WIDTH-1:0] count;
	wire cnt_step;
	wire cnt_wrap;
	wire [9:0] widx;
	wire bus_wr;
	wire bus_rd;
	wire [8*NUM_CH-1:0] ctrl_all;
	wire [CNT_WIDTH*NUM_CH-1:0] val_all;
	wire [NUM_CH-1:0] msb_all;
	wire [NUM_CH-1:0] pin_out_all;
	wire [NUM_CH-1:0] oe_n_all;
	wire [NUM_CH-1:0] irq_all;
	reg [31:0] rd_data;
	reg rd_hit;
	integer k;

	// apb access phase; writes and read side effects happen only here
	assign widx = paddr[11:2];
	assign bus_wr = psel & penable & pready_ff & pwrite;
	assign bus_rd = psel & penable & pready_ff & ~pwrite;

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign channel_pin_out = pin_out_all;
	assign channel_pin_oe_n = oe_n_all;
	assign channel_irq = irq_all;

	tcc_counter #(
		.WIDTH(CNT_WIDTH)
	) u_counter (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.halt(halt_ff),
		.clear(clr_ff),
		.modulo(mod_ff),
		.count_ff(count),
		.step_ff(cnt_step),
		.wrap_ff(cnt_wrap)
	);

	// timer status/control, modulo and the wrap flag
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			halt_ff <= `TCC_RST_HALT;
			clr_ff <= 1'b0;
			mod_ff <= `TCC_RST_MOD;
			wrap_flag_ff <= 1'b0;
			wrap_arm_ff <= 1'b0;
		end
		else
		begin
			// RULE24 clear is a one-cycle pulse
			clr_ff <= bus_wr && widx == `TCC_IDX_TSC && pwdata[`TCC_B_CLR];
			if (bus_wr && widx == `TCC_IDX_TSC)
				halt_ff <= pwdata[`TCC_B_HALT];
			if (bus_wr && widx == `TCC_IDX_MOD)
				mod_ff <= pwdata[CNT_WIDTH-1:0];
			// read-then-zero clearing like the channel flags, but a write does not disarm it, only a wrap; a new wrap wins
			if (cnt_wrap)
				wrap_arm_ff <= 1'b0;
			else if (bus_rd && widx == `TCC_IDX_TSC && wrap_flag_ff)
				wrap_arm_ff <= 1'b1;
			wrap_flag_ff <= cnt_wrap | (wrap_flag_ff & ~(bus_wr && widx == `TCC_IDX_TSC
				&& !pwdata[`TCC_B_WRAP] && wrap_arm_ff));
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM_CH; i = i + 1)
		begin : g_ch
			localparam integer CI = `TCC_IDX_CH_BASE + `TCC_CH_STRIDE * i;
			localparam integer VH = CI + `TCC_VH_OFS;
			localparam integer VL = CI + `TCC_VL_OFS;
			reg flag_ff;
			reg arm_ff;
			reg ie_ff;
			reg msa_ff;
			reg [1:0] els_ff;
			reg tov_ff;
			reg max_ff;
			reg max_eff_ff;
			reg sel_ff;
			reg cap_block_ff;
			reg cmp_inhibit_ff;
			reg [CNT_WIDTH-1:0] val_ff;
			reg out_ff;
			reg oe_n_ff;
			reg irq_ff;
			wire msb;
			wire dis;
			wire rise;
			wire fall;
			wire conn;
			wire ic_mode;
			wire oc_mode;
			wire edge_hit;
			wire cap_ev;
			wire cmp_ev;
			wire evt;
			wire wr_ctrl;
			wire [CNT_WIDTH-1:0] cmp_val;
			wire full_lvl;

			// RULE7 buffered bit only on even channels
			if (i % 2 == 0 && i + 1 < NUM_CH)
			begin : g_msb
				reg msb_ff;
				always @(posedge core_clk or negedge reset_n)
				begin
					if (!reset_n)
						msb_ff <= 1'b0;
					else if (bus_wr && widx == CI[9:0])
						msb_ff <= pwdata[`TCC_B_MSB];
				end
				assign msb = msb_ff;
				// RULE25 compare source alternates with the odd partner
				assign cmp_val = (msb_ff && sel_ff) ? val_all[CNT_WIDTH*(i+1) +: CNT_WIDTH]
					: val_ff;
			end
			else
			begin : g_nomsb
				assign msb = 1'b0;
				assign cmp_val = val_ff;
			end

			// RULE8 odd channel is switched off by its even partner
			if (i % 2 == 1)
			begin : g_dis
				assign dis = msb_all[i-1];
			end
			else
			begin : g_nodis
				assign dis = 1'b0;
			end

			tcc_edge_detect u_edge (
				.core_clk(core_clk),
				.reset_n(reset_n),
				.pin(channel_pin_in[i]),
				.rise(rise),
				.fall(fall)
			);

			// RULE9 mode from edge field and mode bit
			assign conn = (els_ff != `TCC_ELS_OFF) && !dis;
			// RULE13 buffered bit overrides the mode bit
			assign oc_mode = conn && (msb || msa_ff);
			assign ic_mode = conn && !msb && !msa_ff;
			// RULE11 capture edge selection
			assign edge_hit = (els_ff[0] & rise) | (els_ff[1] & fall);
			// RULE1 capture event, RULE22 blocked while high byte pending
			assign cap_ev = ic_mode && edge_hit && !cap_block_ff;
			// RULE2 compare event on a freshly entered count value
			assign cmp_ev = oc_mode && cnt_step && count == cmp_val && !cmp_inhibit_ff;
			assign evt = cap_ev | cmp_ev;
			assign wr_ctrl = bus_wr && widx == CI[9:0] && !dis;
			// full duty level: high unless the action on compare is set
			assign full_lvl = (els_ff != `TCC_ELS_SET);

			// control bits; a disabled channel ignores control writes
			always @(posedge core_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					// RULE21 channels start disconnected
					ie_ff <= 1'b0;
					msa_ff <= 1'b0;
					els_ff <= `TCC_ELS_OFF;
					tov_ff <= 1'b0;
					max_ff <= 1'b0;
				end
				else if (wr_ctrl)
				begin
					// RULE6 enable bit
					ie_ff <= pwdata[`TCC_B_IE];
					msa_ff <= pwdata[`TCC_B_MSA];
					els_ff <= {pwdata[`TCC_B_ELSB], pwdata[`TCC_B_ELSA]};
					tov_ff <= pwdata[`TCC_B_TOV];
					max_ff <= pwdata[`TCC_B_MAX];
				end
			end

			// event flag with read-then-write-zero clearing
			always @(posedge core_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					flag_ff <= 1'b0;
					arm_ff <= 1'b0;
				end
				else
				begin
					// RULE4 a new event cancels a pending clear
					if (evt)
						arm_ff <= 1'b0;
					else if (bus_rd && widx == CI[9:0] && flag_ff)
						arm_ff <= 1'b1;
					else if (wr_ctrl)
						arm_ff <= 1'b0;
					// RULE3 clear only when armed; RULE5 writing one is ignored
					flag_ff <= evt | (flag_ff & ~(wr_ctrl && !pwdata[`TCC_B_FLAG] && arm_ff));
				end
			end

			// value register: captures, byte writes and the high/low byte locks
			always @(posedge core_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					val_ff <= `TCC_CNT_ZERO;
					cap_block_ff <= 1'b0;
					cmp_inhibit_ff <= 1'b0;
				end
				else
				begin
					if (cap_ev)
						val_ff <= count;
					else if (bus_wr && widx == VH[9:0])
						val_ff[15:8] <= pwdata[7:0];
					else if (bus_wr && widx == VL[9:0])
						val_ff[7:0] <= pwdata[7:0];
					// RULE22 high read blocks capture until low read
					if (bus_rd && widx == VH[9:0] && ic_mode)
						cap_block_ff <= 1'b1;
					else if (bus_rd && widx == VL[9:0])
						cap_block_ff <= 1'b0;
					// a half-written compare value never matches
					if (bus_wr && widx == VH[9:0])
						cmp_inhibit_ff <= 1'b1;
					else if (bus_wr && widx == VL[9:0])
						cmp_inhibit_ff <= 1'b0;
				end
			end

			// period-boundary state: full duty latch and buffer select
			always @(posedge core_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					max_eff_ff <= 1'b0;
					sel_ff <= 1'b0;
				end
				else if (cnt_wrap)
				begin
					// RULE19 full duty sampled once per period
					max_eff_ff <= max_ff;
					// RULE25 swap at overflow
					sel_ff <= msb & ~sel_ff;
				end
			end

			// pin output and interrupt request
			always @(posedge core_clk or negedge reset_n)
			begin
				if (!reset_n)
				begin
					out_ff <= 1'b1;
					oe_n_ff <= 1'b1;
					irq_ff <= 1'b0;
				end
				else
				begin
					// RULE6 request only while enabled
					irq_ff <= flag_ff & ie_ff;
					// RULE8 RULE10 pin left to port control unless comparing
					oe_n_ff <= ~oc_mode;
					if (!conn)
						// RULE10 preset level: mode bit one gives low
						out_ff <= ~msa_ff;
					else if (oc_mode)
					begin
						// RULE16 RULE17 overflow toggle wins over compare
						if (cnt_wrap && tov_ff)
							out_ff <= ~out_ff;
						// RULE18 forced full duty
						else if (max_eff_ff && !tov_ff)
							out_ff <= full_lvl;
						else if (cmp_ev)
						begin
							// RULE12 compare action
							case (els_ff)
								`TCC_ELS_TOG: out_ff <= ~out_ff;
								`TCC_ELS_CLR: out_ff <= 1'b0;
								`TCC_ELS_SET: out_ff <= 1'b1;
								default: out_ff <= out_ff;
							endcase
						end
					end
				end
			end

			assign ctrl_all[8*i +: 8] = dis ? 8'h00 :
				{flag_ff, ie_ff, msb, msa_ff, els_ff, tov_ff, max_ff};
			assign val_all[CNT_WIDTH*i +: CNT_WIDTH] = val_ff;
			assign msb_all[i] = msb;
			assign pin_out_all[i] = out_ff;
			assign oe_n_all[i] = oe_n_ff;
			assign irq_all[i] = irq_ff;
		end
	endgenerate

	// read mux; unmapped addresses answer zero with an error
	always @*
	begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b0;
		if (widx == `TCC_IDX_TSC)
		begin
			rd_hit = 1'b1;
			// RULE24 clear bit reads zero
			rd_data[`TCC_B_WRAP] = wrap_flag_ff;
			rd_data[`TCC_B_HALT] = halt_ff;
		end
		else if (widx == `TCC_IDX_CNT)
		begin
			rd_hit = 1'b1;
			rd_data[CNT_WIDTH-1:0] = count;
		end
		else if (widx == `TCC_IDX_MOD)
		begin
			rd_hit = 1'b1;
			rd_data[CNT_WIDTH-1:0] = mod_ff;
		end
		for (k = 0; k < NUM_CH; k = k + 1)
		begin
			if (widx == `TCC_IDX_CH_BASE + `TCC_CH_STRIDE * k)
			begin
				rd_hit = 1'b1;
				rd_data[7:0] = ctrl_all[8*k +: 8];
			end
			if (widx == `TCC_IDX_CH_BASE + `TCC_CH_STRIDE * k + `TCC_VH_OFS)
			begin
				rd_hit = 1'b1;
				rd_data[7:0] = val_all[CNT_WIDTH*k + 8 +: 8];
			end
			if (widx == `TCC_IDX_CH_BASE + `TCC_CH_STRIDE * k + `TCC_VL_OFS)
			begin
				rd_hit = 1'b1;
				rd_data[7:0] = val_all[CNT_WIDTH*k +: 8];
			end
		end
	end

	// apb answer: data and error latched in the setup cycle, ready held high
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
		else
		begin
			pready_ff <= 1'b1;
			if (psel && !penable)
			begin
				prdata_ff <= pwrite ? 32'h0000_0000 : rd_data;
				pslverr_ff <= ~rd_hit;
			end
		end
	end
endmodule

// >>> hdl/tcc_defines.vh
// constants for the four-channel timer capture/compare block
// assumes an apb slave with 32-bit data; register index times four is the byte address
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// register indices (byte address = index * 4)
`define TCC_IDX_TSC 10'h040
`define TCC_IDX_CNT 10'h041
`define TCC_IDX_MOD 10'h043
`define TCC_IDX_CH_BASE 10'h045
`define TCC_CH_STRIDE 3
`define TCC_VH_OFS 1
`define TCC_VL_OFS 2

// channel control/status bit positions
`define TCC_B_FLAG 7
`define TCC_B_IE 6
`define TCC_B_MSB 5
`define TCC_B_MSA 4
`define TCC_B_ELSB 3
`define TCC_B_ELSA 2
`define TCC_B_TOV 1
`define TCC_B_MAX 0

// timer status/control bit positions
`define TCC_B_WRAP 7
`define TCC_B_HALT 5
`define TCC_B_CLR 4

// reset values
`define TCC_RST_MOD 16'hffff
`define TCC_RST_HALT 1'b1
`define TCC_CNT_ZERO 16'h0000
`define TCC_ONE16 16'h0001

// edge/level field encodings
`define TCC_ELS_OFF 2'b00
`define TCC_ELS_TOG 2'b01
`define TCC_ELS_CLR 2'b10
`define TCC_ELS_SET 2'b11

`endif

// >>> hdl/tcc_edge_detect.v
// edge detector for one channel pin
// assumes the pin is already synchronous to core_clk
module tcc_edge_detect
(
	input wire core_clk,
	input wire reset_n,
	input wire pin,
	output wire rise,
	output wire fall
);
	reg prev_ff;

	// previous level is tracked always, so a pin held stable before capture is enabled
	// RULE15 stable pin gives no false edge
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			prev_ff <= 1'b0;
		else
			prev_ff <= pin;
	end

	assign rise = pin & ~prev_ff;
	assign fall = ~pin & prev_ff;
endmodule

// >>> hdl/tcc_counter.v
// shared 16-bit modulo up-counter with halt and clear
// assumes clear is a one-cycle pulse; prescaling is done elsewhere
module tcc_counter
#(
	parameter WIDTH = 16
)
(
	input wire core_clk,
	input wire reset_n,
	input wire halt,
	input wire clear,
	input wire [WIDTH-1:0] modulo,
	output reg [WIDTH-1:0] count_ff,
	output reg step_ff,
	output reg wrap_ff
);
	// step_ff marks a freshly entered count value, wrap_ff the return to zero
	always @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			count_ff <= {WIDTH{1'b0}};
			step_ff <= 1'b0;
			wrap_ff <= 1'b0;
		end
		else if (clear)
		begin
			// RULE24 clear zeroes the counter only
			count_ff <= {WIDTH{1'b0}};
			step_ff <= 1'b1;
			wrap_ff <= 1'b0;
		end
		else if (!halt)
		begin
			step_ff <= 1'b1;
			// RULE23 wrap after modulo
			if (count_ff == modulo)
			begin
				count_ff <= {WIDTH{1'b0}};
				wrap_ff <= 1'b1;
			end
			else
			begin
				count_ff <= count_ff + {{(WIDTH-1){1'b0}}, 1'b1};
				wrap_ff <= 1'b0;
			end
		end
		else
		begin
			step_ff <= 1'b0;
			wrap_ff <= 1'b0;
		end
	end
endmodule

// >>> test/tcc_checker_asserts.sv
// port assertions for the timer capture/compare block
// assumes a bind to tcc_top; channel 0 control is mirrored from apb writes
module tcc_checker
#(
	parameter ADDR_WIDTH = 12,
	parameter CNT_WIDTH = 16,
	parameter NUM_CH = 4
)
(
	input wire core_clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [ADDR_WIDTH-1:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire [NUM_CH-1:0] channel_pin_in,
	input wire [NUM_CH-1:0] channel_pin_oe_n,
	input wire [NUM_CH-1:0] channel_irq
);
	logic [ADDR_WIDTH-3:0] idx;
	logic acc;
	logic wr0;
	logic wr2;
	logic [7:0] ctl0_ff;
	// completed transfers and the writes to channel 0 and 2 control
	assign idx = paddr[ADDR_WIDTH-1:2];
	assign acc = psel && penable && pready;
	assign wr0 = acc && pwrite && idx == 10'h045;
	assign wr2 = acc && pwrite && idx == 10'h04b;
	// mirror updates on the same edge as the register, so no extra lag
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			ctl0_ff <= 8'h00;
		else if (wr0)
			ctl0_ff <= pwdata[7:0];
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	cap_rise_a: assert property (
		ctl0_ff[6:2] == 5'h11 && $rose(channel_pin_in[0]) |-> ##[1:3] channel_irq[0])
		else $error("rising edge gave no interrupt");
	irq_gate_a: assert property (
		channel_irq[0] |-> $past(ctl0_ff[6])) else $error("interrupt while disabled");
	pin_free_a: assert property (
		wr0 && pwdata[3:2] == 2'b00 |-> ##2 channel_pin_oe_n[0]) else $error("pin not freed");
	odd_free_a: assert property (
		wr0 && pwdata[5] |-> ##2 channel_pin_oe_n[1]) else $error("odd pin still driven");
	buf_drive_a: assert property (
		wr0 && pwdata[5] && pwdata[3:2] != 2'b00 |-> ##2 !channel_pin_oe_n[0])
		else $error("buffered pin not driven");
	cmp_drive_a: assert property (
		wr2 && pwdata[5:4] == 2'b01 && pwdata[3:2] != 2'b00 |-> ##2 !channel_pin_oe_n[2])
		else $error("compare pin not driven");
	clr_zero_a: assert property (
		acc && !pwrite && idx == 10'h040 |-> !prdata[4]) else $error("clear bit read one");
	odd_nobuf_a: assert property (
		acc && !pwrite && (idx == 10'h048 || idx == 10'h04e) |-> !prdata[5])
		else $error("odd buffered bit read one");
	rst_pins_a: assert property (
		!$past(reset_n) |-> &channel_pin_oe_n) else $error("pins driven after reset");
endmodule

// >>> test/tcc_pin_model.sv
// outside world of the four channel pins
// assumes the bench sets the level an outside source puts on each pin
module tcc_pin_model
(
	input wire [3:0] ext_lvl,
	input wire [3:0] pin_out,
	input wire [3:0] pin_oe_n,
	output wire [3:0] pin_in
);
	// a driven pin shows the block's level, a released one the outside source
	assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_lvl);
endmodule

// >>> test/tcc_top_tb.sv
// self-checking bench for the timer capture/compare block
// assumes tcc_top, the pin model and the checker are compiled alongside
module tcc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] ext_lvl = 4'h0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [3:0] pin_in;
	wire [3:0] pin_out;
	wire [3:0] oe_n;
	wire [3:0] irq;
	logic [32:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	tcc_top tcc_top_inst
	(
		.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .channel_pin_in(pin_in),
		.channel_pin_out(pin_out), .channel_pin_oe_n(oe_n), .channel_irq(irq)
	);
	tcc_pin_model tcc_pin_model_inst
	(
		.ext_lvl(ext_lvl), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in)
	);
	// clock at 125 MHz
	initial
	begin
		forever #4 core_clk = ~core_clk;
	end
	task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] s);
		tests_run++;
		if (s !== e)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// a hang counts as a mismatch and ends the run
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			results();
		end
	end
	// read data and error are compared against the oldest note
	always @(posedge core_clk)
	begin
		if (psel && penable && pready && !pwrite)
			chk("read", exp_q.pop_front(), {pslverr, prdata});
	end
	// one apb transfer; the request holds until pready is seen high
	task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [9:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h000000, d});
	endtask
	task automatic rd(input logic [9:0] idx, input logic [32:0] e);
		exp_q.push_back(e);
		apb(1'b0, idx, $urandom);
	endtask
	// move the outside level of pin 0 and let flag and interrupt settle
	task automatic pin0(input logic lvl);
		@(posedge core_clk);
		ext_lvl[0] <= lvl;
		repeat (4) @(posedge core_clk);
	endtask
	// main sequence
	initial
	begin
		logic [7:0] cfg;
		logic [7:0] v;
		logic p0;
		int wt;
		void'($urandom(32'h9421dfe4));
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		for (int n = 0; n < 4; n++)
			rd(10'(10'h045 + 3 * n), 33'h0);
		chk("oe_n", 33'hf, {29'h0, oe_n});
		rd(10'h040, 33'h20);
		rd(10'h3ff, {1'b1, 32'h0});
		$display("test reset done");
		for (int m = 1; m < 4; m++)
		begin
			cfg = 8'(8'h40 | (m << 2));
			wr(10'h045, cfg);
			repeat (2) @(posedge core_clk);
			pin0(1'b1);
			chk("irq0", {32'h0, m[0]}, {32'h0, irq[0]});
			rd(10'h045, {25'h0, m[0], cfg[6:0]});
			wr(10'h045, cfg);
			pin0(1'b0);
			rd(10'h045, {25'h0, m[1], cfg[6:0]});
			wr(10'h045, cfg);
			rd(10'h045, {25'h0, cfg});
		end
		$display("test capture done");
		wr(10'h045, 8'h44);
		pin0(1'b1);
		rd(10'h045, 33'hc4);
		pin0(1'b0);
		pin0(1'b1);
		wr(10'h045, 8'h44);
		rd(10'h045, 33'hc4);
		wr(10'h045, 8'hc4);
		rd(10'h045, 33'hc4);
		// writing one keeps the flag, so only the enable goes away here
		wr(10'h045, 8'h84);
		repeat (3) @(posedge core_clk);
		chk("irq0", 33'h0, {32'h0, irq[0]});
		rd(10'h045, 33'h84);
		wr(10'h045, 8'h04);
		rd(10'h045, 33'h04);
		// a pending high-byte read must swallow the next capture
		rd(10'h046, 33'h0);
		pin0(1'b0);
		pin0(1'b1);
		rd(10'h045, 33'h04);
		rd(10'h047, 33'h0);
		pin0(1'b0);
		pin0(1'b1);
		rd(10'h045, 33'h84);
		wr(10'h045, 8'h04);
		$display("test flag done");
		v = 8'($urandom_range(143, 16));
		wr(10'h04c, 8'h00);
		wr(10'h04d, v);
		for (int m = 1; m < 4; m++)
		begin
			cfg = 8'(8'h50 | (m << 2));
			wr(10'h040, 8'h30);
			wr(10'h04b, cfg);
			repeat (2) @(posedge core_clk);
			p0 = pin_out[2];
			wr(10'h040, 8'h00);
			for (int k = 0; k < 300 && irq[2] !== 1'b1; k++)
				@(posedge core_clk);
			chk("pin2", {32'h0, (m == 1) ? ~p0 : m[0]}, {32'h0, pin_out[2]});
			rd(10'h04b, {25'h1, cfg[6:0]});
			wr(10'h04b, cfg);
		end
		$display("test compare done");
		// short modulo; high byte write alone keeps channel 2 compares inhibited
		wr(10'h040, 8'h30);
		wr(10'h043, 8'h1f);
		wr(10'h04c, 8'h01);
		wr(10'h04b, 8'h56);
		@(negedge core_clk);
		p0 = pin_out[2];
		wr(10'h040, 8'h00);
		for (wt = 0; wt < 100 && pin_out[2] === p0; wt++)
			@(negedge core_clk);
		chk("tov_pin", {32'h0, ~p0}, {32'h0, pin_out[2]});
		p0 = pin_out[2];
		for (wt = 0; wt < 100 && pin_out[2] === p0; wt++)
			@(negedge core_clk);
		chk("period", 33'h20, 33'(wt));
		wr(10'h040, 8'h20);
		rd(10'h040, 33'ha0);
		wr(10'h040, 8'h20);
		rd(10'h040, 33'h20);
		// full duty level is the opposite of the present pin level
		@(negedge core_clk);
		p0 = pin_out[2];
		wr(10'h04b, p0 ? 8'h5d : 8'h55);
		repeat (4) @(negedge core_clk);
		chk("max_hold", {32'h0, p0}, {32'h0, pin_out[2]});
		wr(10'h040, 8'h00);
		for (wt = 0; wt < 100 && pin_out[2] === p0; wt++)
			@(negedge core_clk);
		chk("max_pin", {32'h0, ~p0}, {32'h0, pin_out[2]});
		$display("test overflow done");
		wr(10'h040, 8'h30);
		wr(10'h048, 8'h20);
		rd(10'h048, 33'h0);
		wr(10'h045, 8'h2c);
		wr(10'h048, 8'h54);
		rd(10'h048, 33'h0);
		rd(10'h045, 33'h2c);
		chk("oe_n", 33'h2, {31'h0, oe_n[1:0]});
		wr(10'h045, 8'h00);
		repeat (2) @(posedge core_clk);
		chk("oe_n", 33'h1, {32'h0, oe_n[0]});
		$display("test buffered done");
		results();
	end
endmodule
bind tcc_top tcc_checker
#(
	.ADDR_WIDTH(ADDR_WIDTH), .CNT_WIDTH(CNT_WIDTH), .NUM_CH(NUM_CH)
)
tcc_checker_inst
(
	.core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.channel_pin_in(channel_pin_in), .channel_pin_oe_n(channel_pin_oe_n),
	.channel_irq(channel_irq)
);
